// ==== sio_port.sv ====
// Shared pin I/O port: package and top level with register slave
// Overview of operation
// - Per pin, a multiplexer gives output data and enable to peripheral or port.
// - Port's own driven output never loops into the sharing peripheral's input.
// - Enabled peripheral actively driving a pin disables port driver; pin stays readable.
// - Enabled but idle peripheral lets the port drive the pin.
// - Direction bit 1 makes the pin an input, 0 an output.
// - After reset every direction bit is set, all pins inputs.
// - Output hold register reads back its latch; writes update the latch.
// - Pin level register reads sampled pins; writes go to the output latch.
// - Unimplemented bits read zero except in the two analog configuration registers, and never drive.
// - Pins shared only with input functions behave as dedicated port bits.
// - Open-drain bit set makes the pin output open-drain.
// - Clearing an analog configuration bit makes the pin analog.
// - Pins with analog function come out of reset as analog.
// - Pin is analog when cleared in either converter's configuration register.
// - Pin level reads return zero for analog-configured pins.
// - Change logic raises an interrupt request when a selected input changes.
// - Change detection still catches changes made while clocks are stopped.
// - Up to 24 change inputs, numbered 0 through 23.
// - Each change input has its own interrupt enable bit.
// - Each change input has its own weak pull-up enable bit.
`timescale 1ns/10ps
package sio_pkg;
  localparam int PORT_W = 16;
  localparam int CN_W = 24;
  localparam int CN_LO_W = 16;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_DIR = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_HOLD = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_ODC = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_ANA1 = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_ANA2 = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_CHANGE_IRQ_ENABLE_1 = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CHANGE_IRQ_ENABLE_2 = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_WEAK_PULLUP_ENABLE_1 = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_WEAK_PULLUP_ENABLE_2 = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_CHG = 6'h28;
  localparam int CHG_FLAG_BIT = 0;
  localparam logic [PORT_W-1:0] DIR_RESET = 16'hFFFF;
  localparam logic [PORT_W-1:0] HOLD_RESET = 16'h0000;
  localparam logic [PORT_W-1:0] ODC_RESET = 16'h0000;
  localparam logic [CN_W-1:0] CN_RESET = 24'h000000;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] hold;
    logic [PORT_W-1:0] odc;
  } sio_cfg_type;

  typedef enum logic {
    BUS_ACK = 1'b0,
    BUS_WAIT = 1'b1
  } sio_bus_type;

  // Byte-lane merge of a write into a stored value
  function automatic logic [31:0] sio_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : sio_merge
endpackage : sio_pkg

module sio_port import sio_pkg::*; #(
  parameter logic [PORT_W-1:0] IMPL_MASK = 16'hFFFF,
  parameter logic [PORT_W-1:0] ANALOG_MASK = 16'h00FF,
  parameter logic [PORT_W-1:0] INPUT_ONLY_MASK = 16'h0000,
  parameter logic [CN_W-1:0] CN_MASK = 24'hFFFFFF
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic ARST_N,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Port pins
  input wire logic [PORT_W-1:0] PIN_IN,
  output logic [PORT_W-1:0] PIN_OUT,
  output logic [PORT_W-1:0] PIN_OE,
  // Sharing peripherals
  input wire logic [PORT_W-1:0] PERIPH_ENABLE,
  input wire logic [PORT_W-1:0] PERIPH_OE,
  input wire logic [PORT_W-1:0] PERIPH_OUT,
  output logic [PORT_W-1:0] PERIPH_IN,
  // Analog pin selection
  output logic [PORT_W-1:0] ANALOG_MODE,
  // Change notification
  input wire logic [CN_W-1:0] CHANGE_NOTIFY_IN,
  output logic [CN_W-1:0] WEAK_PULLUP,
  output logic CHANGE_IRQ
);
  sio_bus_type bus_state;
  sio_cfg_type cfg;
  logic [PORT_W-1:0] ana1;
  logic [PORT_W-1:0] ana2;
  logic [CN_W-1:0] cn_irq_en;
  logic [CN_W-1:0] cn_pullup;
  logic [CN_W-1:0] cn_prev;
  logic change_flag;
  logic [PORT_W-1:0] pin_sync;
  logic [CN_W-1:0] cn_sync;
  logic [PORT_W-1:0] analog_now;
  logic [PORT_W-1:0] level_now;
  logic [CN_W-1:0] cn_diff;
  logic [31:0] next_readdata;
  logic wr_go;
  logic wr_hold;
  logic [31:0] hold_merged;
  logic [31:0] dir_merged;
  logic [31:0] odc_merged;
  logic [31:0] ana1_merged;
  logic [31:0] ana2_merged;

  sio_sync #(.W(PORT_W)) u_pin_sync (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .d(PIN_IN),
    .q(pin_sync)
  );

  sio_sync #(.W(CN_W)) u_cn_sync (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .d(CHANGE_NOTIFY_IN),
    .q(cn_sync)
  );

  sio_pin_mux #(.IMPL_MASK(IMPL_MASK), .INPUT_ONLY_MASK(INPUT_ONLY_MASK)) u_mux (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .cfg(cfg),
    .periph_en(PERIPH_ENABLE),
    .periph_oe(PERIPH_OE),
    .periph_out(PERIPH_OUT),
    .pin_sync(pin_sync),
    .pin_out(PIN_OUT),
    .pin_oe(PIN_OE),
    .periph_in(PERIPH_IN)
  );

  // A zero in either converter's register makes the pin analog
  assign analog_now = ~(ana1 & ana2) & ANALOG_MASK & IMPL_MASK;
  // Analog pins read low; sampled level already lags two edges
  assign level_now = pin_sync & ~analog_now & IMPL_MASK;
  assign wr_go = AVS_WRITE && bus_state == BUS_ACK;
  assign wr_hold = wr_go && (AVS_ADDRESS == OFS_HOLD || AVS_ADDRESS == OFS_LEVEL);
  assign hold_merged = sio_merge({16'h0000, cfg.hold}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign dir_merged = sio_merge({16'h0000, cfg.dir}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign odc_merged = sio_merge({16'h0000, cfg.odc}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign ana1_merged = sio_merge({16'h0000, ana1}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign ana2_merged = sio_merge({16'h0000, ana2}, AVS_WRITEDATA, AVS_BYTEENABLE);

  always_comb begin
    next_readdata = READ_ZERO;
    unique case (AVS_ADDRESS)
      OFS_DIR: next_readdata[PORT_W-1:0] = cfg.dir & IMPL_MASK;
      OFS_HOLD: next_readdata[PORT_W-1:0] = cfg.hold & IMPL_MASK;
      OFS_LEVEL: next_readdata[PORT_W-1:0] = level_now;
      OFS_ODC: next_readdata[PORT_W-1:0] = cfg.odc & IMPL_MASK;
      OFS_ANA1: next_readdata[PORT_W-1:0] = ana1;
      OFS_ANA2: next_readdata[PORT_W-1:0] = ana2;
      OFS_CHANGE_IRQ_ENABLE_1: next_readdata[CN_LO_W-1:0] = cn_irq_en[CN_LO_W-1:0];
      OFS_CHANGE_IRQ_ENABLE_2: next_readdata[CN_W-CN_LO_W-1:0] = cn_irq_en[CN_W-1:CN_LO_W];
      OFS_WEAK_PULLUP_ENABLE_1: next_readdata[CN_LO_W-1:0] = cn_pullup[CN_LO_W-1:0];
      OFS_WEAK_PULLUP_ENABLE_2: next_readdata[CN_W-CN_LO_W-1:0] = cn_pullup[CN_W-1:CN_LO_W];
      OFS_CHG: next_readdata[CHG_FLAG_BIT] = change_flag;
      default: next_readdata = READ_ZERO;
    endcase
  end

  // One wait cycle per access, then a single acknowledging cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_state <= BUS_WAIT;
      AVS_READDATA <= READ_ZERO;
    end else begin
      unique case (bus_state)
        BUS_WAIT: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state <= BUS_ACK;
            AVS_READDATA <= AVS_READ ? next_readdata : READ_ZERO;
          end
        end
        BUS_ACK: begin
          bus_state <= BUS_WAIT;
          AVS_READDATA <= READ_ZERO;
        end
      endcase
    end
  end

  assign AVS_WAITREQUEST = bus_state;

  // Port configuration registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg.dir <= DIR_RESET;
      cfg.hold <= HOLD_RESET;
      cfg.odc <= ODC_RESET;
    end else begin
      if (wr_go && AVS_ADDRESS == OFS_DIR) begin
        cfg.dir <= dir_merged[PORT_W-1:0] | ~IMPL_MASK;
      end
      if (wr_hold) begin
        cfg.hold <= hold_merged[PORT_W-1:0] & IMPL_MASK;
      end
      if (wr_go && AVS_ADDRESS == OFS_ODC) begin
        cfg.odc <= odc_merged[PORT_W-1:0] & IMPL_MASK;
      end
    end
  end

  // Bits with no analog function stay set, so they can never turn analog
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ana1 <= ~ANALOG_MASK;
      ana2 <= ~ANALOG_MASK;
    end else begin
      if (wr_go && AVS_ADDRESS == OFS_ANA1) begin
        ana1 <= ana1_merged[PORT_W-1:0] | ~ANALOG_MASK;
      end
      if (wr_go && AVS_ADDRESS == OFS_ANA2) begin
        ana2 <= ana2_merged[PORT_W-1:0] | ~ANALOG_MASK;
      end
    end
  end

  // Change-notification enables and pull-ups
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cn_irq_en <= CN_RESET;
      cn_pullup <= CN_RESET;
    end else begin
      if (wr_go && AVS_ADDRESS == OFS_CHANGE_IRQ_ENABLE_1) begin
        cn_irq_en[CN_LO_W-1:0] <= AVS_WRITEDATA[CN_LO_W-1:0] & CN_MASK[CN_LO_W-1:0];
      end
      if (wr_go && AVS_ADDRESS == OFS_CHANGE_IRQ_ENABLE_2) begin
        cn_irq_en[CN_W-1:CN_LO_W] <= AVS_WRITEDATA[CN_W-CN_LO_W-1:0]
                                     & CN_MASK[CN_W-1:CN_LO_W];
      end
      if (wr_go && AVS_ADDRESS == OFS_WEAK_PULLUP_ENABLE_1) begin
        cn_pullup[CN_LO_W-1:0] <= AVS_WRITEDATA[CN_LO_W-1:0] & CN_MASK[CN_LO_W-1:0];
      end
      if (wr_go && AVS_ADDRESS == OFS_WEAK_PULLUP_ENABLE_2) begin
        cn_pullup[CN_W-1:CN_LO_W] <= AVS_WRITEDATA[CN_W-CN_LO_W-1:0]
                                     & CN_MASK[CN_W-1:CN_LO_W];
      end
    end
  end

  // Previous sample is only updated on a clock edge, so a change made
  // while the clock is stopped reaches cn_diff at the second edge after restart
  assign cn_diff = (cn_sync ^ cn_prev) & cn_irq_en;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      cn_prev <= CN_RESET;
    end else begin
      cn_prev <= cn_sync;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      change_flag <= 1'b0;
    end else if (|cn_diff) begin
      change_flag <= 1'b1;
    end else if (wr_go && AVS_ADDRESS == OFS_CHG && AVS_BYTEENABLE[0]
                 && AVS_WRITEDATA[CHG_FLAG_BIT]) begin
      change_flag <= 1'b0;
    end
  end

  assign CHANGE_IRQ = change_flag;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ANALOG_MODE <= 16'hFFFF & ANALOG_MASK & IMPL_MASK;
      WEAK_PULLUP <= CN_RESET;
    end else begin
      ANALOG_MODE <= analog_now;
      WEAK_PULLUP <= cn_pullup;
    end
  end

  property p_hold_write;
    @(posedge CLOCK) disable iff (!ARST_N)
    wr_hold |=> cfg.hold == ($past(hold_merged[PORT_W-1:0]) & IMPL_MASK);
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold latch missed write");

  property p_level_analog;
    @(posedge CLOCK) disable iff (!ARST_N)
    (bus_state == BUS_WAIT && AVS_READ && AVS_ADDRESS == OFS_LEVEL)
      |=> (AVS_READDATA[PORT_W-1:0] & $past(analog_now)) == 16'h0000;
  endproperty
  a_level_analog: assert property (p_level_analog) else $error("analog pin read high");

  property p_change_flag;
    @(posedge CLOCK) disable iff (!ARST_N)
    (|cn_diff) |=> change_flag && CHANGE_IRQ;
  endproperty
  a_change_flag: assert property (p_change_flag) else $error("change not flagged");

  property p_answer;
    @(posedge CLOCK) disable iff (!ARST_N)
    (AVS_READ || AVS_WRITE) |-> ##[0:1] !AVS_WAITREQUEST;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer too late");

  property p_dir_write_input;
    @(posedge CLOCK) disable iff (!ARST_N)
    (wr_go && AVS_ADDRESS == OFS_DIR && AVS_BYTEENABLE == 4'hF
     && AVS_WRITEDATA[PORT_W-1:0] == 16'hFFFF)
      |=> ##1 (PIN_OE & ~$past(PERIPH_ENABLE & PERIPH_OE)) == 16'h0000;
  endproperty
  a_dir_write_input: assert property (p_dir_write_input) else $error("input pin driven");

  c_level_read: cover property (@(posedge CLOCK) disable iff (!ARST_N)
    bus_state == BUS_ACK && AVS_READ && AVS_ADDRESS == OFS_LEVEL);
  c_change: cover property (@(posedge CLOCK) disable iff (!ARST_N) $rose(CHANGE_IRQ));
  c_clear: cover property (@(posedge CLOCK) disable iff (!ARST_N) $fell(CHANGE_IRQ));
endmodule : sio_port

// ==== sio_sync.sv ====
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module sio_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sio_sync

// ==== sio_pin_mux.sv ====
// Per-pin output ownership, open-drain and loop-through blocking
`timescale 1ns/10ps
module sio_pin_mux import sio_pkg::*; #(
  parameter logic [PORT_W-1:0] IMPL_MASK = 16'hFFFF,
  parameter logic [PORT_W-1:0] INPUT_ONLY_MASK = 16'h0000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Port settings
  input wire sio_cfg_type cfg,
  // Peripheral side
  input wire logic [PORT_W-1:0] periph_en,
  input wire logic [PORT_W-1:0] periph_oe,
  input wire logic [PORT_W-1:0] periph_out,
  input wire logic [PORT_W-1:0] pin_sync,
  // Pin side
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe,
  output logic [PORT_W-1:0] periph_in
);
  logic [PORT_W-1:0] periph_owns;
  logic [PORT_W-1:0] port_drives;
  logic [PORT_W-1:0] sel_out;
  logic [PORT_W-1:0] sel_oe;
  logic [PORT_W-1:0] next_oe;

  // Input-only sharers never claim the driver
  assign periph_owns = periph_en & periph_oe & ~INPUT_ONLY_MASK;
  assign port_drives = ~periph_owns & ~cfg.dir;
  assign sel_out = (periph_owns & periph_out) | (~periph_owns & cfg.hold);
  assign sel_oe = periph_owns | port_drives;
  // Open drain releases the pin instead of driving high
  assign next_oe = sel_oe & ~(cfg.odc & sel_out) & IMPL_MASK;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= sel_out & ~cfg.odc & IMPL_MASK;
      pin_oe <= next_oe;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      periph_in <= '0;
    end else begin
      periph_in <= pin_sync & ~port_drives & IMPL_MASK;
    end
  end

  property p_periph_owns;
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> (pin_oe & $past(periph_owns & ~cfg.odc & IMPL_MASK))
             == $past(periph_owns & ~cfg.odc & IMPL_MASK);
  endproperty
  a_periph_owns: assert property (p_periph_owns) else $error("peripheral lost pin");

  property p_port_idle_periph;
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> (pin_out & $past(periph_en & ~periph_oe & ~cfg.dir & ~cfg.odc & IMPL_MASK))
             == $past(cfg.hold & periph_en & ~periph_oe & ~cfg.dir & ~cfg.odc & IMPL_MASK);
  endproperty
  a_port_idle_periph: assert property (p_port_idle_periph) else $error("port blocked");

  property p_input_dir;
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> (pin_oe & $past(cfg.dir & ~periph_owns)) == 16'h0000;
  endproperty
  a_input_dir: assert property (p_input_dir) else $error("input pin driven");

  property p_no_loop;
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> (periph_in & $past(port_drives)) == 16'h0000;
  endproperty
  a_no_loop: assert property (p_no_loop) else $error("port output looped in");

  property p_unimpl;
    @(posedge clock) disable iff (!arst_n)
    ((pin_oe | pin_out | periph_in) & ~IMPL_MASK) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit active");

  property p_open_drain;
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> (pin_out & $past(cfg.odc)) == 16'h0000;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  c_periph_drive: cover property (@(posedge clock) disable iff (!arst_n) |periph_owns);
endmodule : sio_pin_mux

// ==== sio_pin_model.sv ====
// Far-side model of the port pins: resolves each pin from all drivers
`timescale 1ns/10ps
module sio_pin_model import sio_pkg::*; (
  // Clock
  input wire logic clock,
  // Device side
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe,
  output logic [PORT_W-1:0] pin_in,
  // External drivers
  input wire logic [PORT_W-1:0] ext_en,
  input wire logic [PORT_W-1:0] ext_val
);
  logic [PORT_W-1:0] last = 16'h0000;

  // Floating pins flip each cycle, so a stale level never passes for a driven one
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : ~last[i]);
    end
  end

  always_ff @(posedge clock) begin
    last <= pin_in;
  end
endmodule : sio_pin_model

// ==== shared_pin_io_port_bench.sv ====
// Self-checking bench for the shared-pin port block
`timescale 1ns/10ps
module shared_pin_io_port_bench import sio_pkg::*;;
  logic CLOCK = 1'b0;
  logic run = 1'b1;
  logic ARST_N = 1'b0;
  logic [ADDR_W-1:0] AVS_ADDRESS = 6'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic [PORT_W-1:0] PIN_IN, PIN_OUT, PIN_OE, PERIPH_IN, ANALOG_MODE;
  logic [PORT_W-1:0] PERIPH_ENABLE = 16'h0000;
  logic [PORT_W-1:0] PERIPH_OE = 16'h0000;
  logic [PORT_W-1:0] PERIPH_OUT = 16'h0000;
  logic [PORT_W-1:0] ext_en = 16'h0000;
  logic [PORT_W-1:0] ext_val = 16'h0000;
  logic [CN_W-1:0] CHANGE_NOTIFY_IN = 24'h000000;
  logic [CN_W-1:0] WEAK_PULLUP;
  logic CHANGE_IRQ;
  int mismatches = 0;
  int comparisons = 0;

  // Gated so a stopped-clock sleep can be imitated
  always #25 CLOCK = run ? ~CLOCK : CLOCK;

  // Bit 15 absent, bit 14 shared with an input-only function
  sio_port #(.IMPL_MASK(16'h7FFF), .INPUT_ONLY_MASK(16'h4000)) u_dut (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PERIPH_ENABLE(PERIPH_ENABLE), .PERIPH_OE(PERIPH_OE),
    .PERIPH_OUT(PERIPH_OUT), .PERIPH_IN(PERIPH_IN), .ANALOG_MODE(ANALOG_MODE),
    .CHANGE_NOTIFY_IN(CHANGE_NOTIFY_IN), .WEAK_PULLUP(WEAK_PULLUP), .CHANGE_IRQ(CHANGE_IRQ));

  sio_pin_model u_pins (.clock(CLOCK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_in(PIN_IN),
    .ext_en(ext_en), .ext_val(ext_val));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task close_out;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // One Avalon access; the request stands until waitrequest is sampled low
  task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge CLOCK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    chk({31'h0, AVS_WAITREQUEST}, 32'h0, "bus answer");
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLOCK);
  endtask : bus

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, READ_ZERO, q);
    chk(q, e, what);
  endtask : rd

  task wt(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : wt

  task wait_irq;
    int n;
    n = 0;
    while (CHANGE_IRQ !== 1'b1 && n < 6) begin
      @(posedge CLOCK);
      n++;
    end
    chk({31'h0, CHANGE_IRQ}, 32'h1, "change irq raised");
  endtask : wait_irq

  task t_reset;
    rd(OFS_DIR, 32'h00007FFF, "dir after reset");
    rd(OFS_HOLD, 32'h00000000, "hold after reset");
    rd(OFS_ANA1, 32'h0000FF00, "analog cfg after reset");
    chk({16'h0000, ANALOG_MODE}, 32'h000000FF, "analog mode after reset");
    chk({16'h0000, PIN_OE}, 32'h00000000, "no drive after reset");
    rd(6'h3C, 32'h00000000, "unmapped read");
    $display("Test reset done");
  endtask : t_reset

  task t_port;
    wr(OFS_ANA1, 32'h0000FFFF);
    wr(OFS_ANA2, 32'h0000FFFF);
    ext_en <= 16'hFF00;
    ext_val <= 16'hDA00;
    wr(OFS_HOLD, 32'h0000FFA5);
    wr(OFS_DIR, 32'h0000FF00);
    wt(4);
    chk({16'h0000, PIN_OE}, 32'h000000FF, "direction to drivers");
    chk({16'h0000, PIN_OUT & PIN_OE}, 32'h000000A5, "driven levels");
    rd(OFS_HOLD, 32'h00007FA5, "hold readback");
    rd(OFS_LEVEL, 32'h00005AA5, "pin level readback");
    wr(OFS_LEVEL, 32'h00001234);
    rd(OFS_HOLD, 32'h00001234, "level write lands in hold");
    wt(4);
    chk({16'h0000, PIN_OUT & PIN_OE}, 32'h00000034, "level write drives");
    $display("Test port done");
  endtask : t_port

  task t_periph;
    wr(OFS_HOLD, 32'h000040A5);
    ext_en <= 16'h3F00;
    wr(OFS_DIR, 32'h00003F00);
    PERIPH_ENABLE <= 16'h4003;
    PERIPH_OE <= 16'h4001;
    PERIPH_OUT <= 16'h0000;
    wt(4);
    chk({16'h0000, PIN_OE & 16'h4007}, 32'h00004007, "owner enables");
    chk({16'h0000, PIN_OUT & 16'h4007}, 32'h00004004, "owner data");
    chk({16'h0000, PERIPH_IN & 16'h0006}, 32'h00000000, "no loop-through");
    chk({16'h0000, PERIPH_IN & 16'h3F00}, 32'h00001A00, "inputs reach peripheral");
    rd(OFS_LEVEL, 32'h00005AA4, "peripheral pin readable");
    wr(OFS_ODC, 32'h00000006);
    wt(4);
    chk({16'h0000, PIN_OE & 16'h0006}, 32'h00000002, "open drain high releases");
    chk({16'h0000, PIN_OUT & 16'h0006}, 32'h00000000, "open drain drives low");
    wr(OFS_ODC, 32'h00000000);
    PERIPH_ENABLE <= 16'h0000;
    PERIPH_OE <= 16'h0000;
    $display("Test peripheral done");
  endtask : t_periph

  task t_analog;
    ext_en <= 16'h3F0C;
    ext_val <= 16'hDA0C;
    wr(OFS_DIR, 32'h00003F0C);
    wr(OFS_ANA1, 32'h0000FFFB);
    wr(OFS_ANA2, 32'h0000FFF7);
    wt(4);
    chk({16'h0000, ANALOG_MODE}, 32'h0000000C, "analog from either reg");
    rd(OFS_LEVEL, 32'h00005AA1, "analog pins read low");
    wr(OFS_ANA1, 32'h0000FFFF);
    wr(OFS_ANA2, 32'h0000FFFF);
    wr(OFS_DIR, 32'h0000FFFF);
    wt(2);
    chk({16'h0000, PIN_OE}, 32'h00000000, "all inputs release pins");
    $display("Test analog done");
  endtask : t_analog

  task t_change;
    // Pull-ups only where no pin is a digital output
    wr(OFS_WEAK_PULLUP_ENABLE_1, 32'h00000001);
    wr(OFS_WEAK_PULLUP_ENABLE_2, 32'h00000080);
    wt(2);
    chk({8'h00, WEAK_PULLUP}, 32'h00800001, "pull-up enables");
    wr(OFS_CHANGE_IRQ_ENABLE_2, 32'h00000080);
    wt(4);
    CHANGE_NOTIFY_IN <= 24'h800000;
    wait_irq();
    rd(OFS_CHG, 32'h00000001, "change flag set");
    wr(OFS_CHG, 32'h00000001);
    wt(2);
    chk({31'h0, CHANGE_IRQ}, 32'h0, "flag cleared");
    CHANGE_NOTIFY_IN <= 24'h800020;
    wt(6);
    chk({31'h0, CHANGE_IRQ}, 32'h0, "disabled input ignored");
    run = 1'b0;
    #400;
    CHANGE_NOTIFY_IN <= 24'h000020;
    #400;
    run = 1'b1;
    wait_irq();
    $display("Test change done");
  endtask : t_change

  initial begin
    repeat (10) @(posedge CLOCK);
    ARST_N <= 1'b1;
    @(posedge CLOCK);
    t_reset();
    t_port();
    t_periph();
    t_analog();
    t_change();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(5000 * 50);
    mismatches++;
    close_out();
  end
endmodule : shared_pin_io_port_bench
